// [io_controller_serial_timers.v]
`default_nettype none
`include "io_ctl_map.vh"
module io_controller_serial_timers (
   // Clock and reset
   input wire clock_i,
   input wire reset_i,
   // Register port
   input wire [4:0] addr_i,
   input wire [15:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   output reg [15:0] rdata_o,
   // Interrupt sources and outputs
   input wire [11:0] ext_irq_i,
   output reg irq_o,
   output reg fast_interrupt_request_o,
   // Keyboard serial link and baud pin
   input wire kbd_rx_i,
   output reg kbd_tx_o,
   output reg baud_o,
   // General I/O pins
   input wire [5:0] gpio_in_i,
   output reg [5:0] gpio_out_o,
   output reg [5:0] gpio_oe_o,
   // System side cycle handshake
   input wire io_cycle_request_i,
   input wire [2:0] io_sel_i,
   input wire io_write_i,
   output reg io_cycle_grant_o,
   // Peripheral bus
   output reg [6:0] periph_sel_o,
   output reg periph_rd_o,
   output reg periph_wr_o,
   output reg bus_buffer_en_o
);
   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   localparam NCNT = 4;
   localparam P_IDLE = 2'b00;
   localparam P_ACC = 2'b01;
   localparam P_HOLD = 2'b10;
   reg [11:0] ext_s1_r;
   reg [11:0] ext_s2_r;
   reg [5:0] gpio_s1_r;
   reg [5:0] gpio_s2_r;
   reg rx_s1_r;
   reg rx_s2_r;
   reg [1:0] edge_st_r;
   reg [15:0] irq_mask_r;
   reg [15:0] fiq_mask_r;
   reg [15:0] irq_req_r;
   reg [15:0] fiq_req_r;
   reg [5:0] gpio_dir_r;
   reg [5:0] gpio_val_r;
   reg [7:0] kbd_rx_buf_r;
   reg rx_full_r;
   reg ferr_r;
   reg ovr_r;
   reg [13:0] psel_time_r;
   reg [1:0] pst_r;
   reg [7:0] pcnt_r;
   reg [2:0] psel_r;
   reg prd_nxt;
   wire [15:0] status_w;
   wire [NCNT-1:0] cnt_tick_w;
   wire [16*NCNT-1:0] cnt_val_w;
   wire [NCNT-1:0] cnt_load_w;
   wire kb_tx_w;
   wire kb_busy_w;
   wire [7:0] kb_data_w;
   wire kb_valid_w;
   wire kb_ferr_w;
   wire kb_start_w;
   wire data_rd_w;
   wire [1:0] edge_clr_w;
   wire [1:0] len_sel_w;
   reg [7:0] len_cyc_w;
   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   // Two flops on every asynchronous pin
   always @(posedge clock_i) begin
      if (reset_i) begin
         ext_s1_r <= 12'h000;
         ext_s2_r <= 12'h000;
         gpio_s1_r <= 6'h00;
         gpio_s2_r <= 6'h00;
         rx_s1_r <= 1'b1;
         rx_s2_r <= 1'b1;
      end else begin
         ext_s1_r <= ext_irq_i;
         ext_s2_r <= ext_s1_r;
         gpio_s1_r <= gpio_in_i;
         gpio_s2_r <= gpio_s1_r;
         rx_s1_r <= kbd_rx_i;
         rx_s2_r <= rx_s1_r;
      end
   end
   // ----------------------------------------
   // Counters
   // ----------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < NCNT; gi = gi + 1) begin : g_cnt
         assign cnt_load_w[gi] = wr_i && (addr_i == `ADR_CNT_BASE + gi);
         reload_counter #(.WIDTH(16)) u_cnt (
            .clock_i(clock_i),
            .reset_i(reset_i),
            .load_i(cnt_load_w[gi]),
            .value_i(wdata_i),
            .count_o(cnt_val_w[16*gi+15:16*gi]),
            .tick_o(cnt_tick_w[gi])
         );
      end
   endgenerate
   // fourth counter toggles the baud pin
   always @(posedge clock_i) begin
      if (reset_i) begin
         baud_o <= 1'b0;
      end else if (cnt_tick_w[3]) begin
         baud_o <= ~baud_o;
      end
   end
   // ----------------------------------------
   // Keyboard serial link
   // ----------------------------------------
   assign kb_start_w = wr_i && (addr_i == `ADR_KBD_DATA);
   assign data_rd_w = rd_i && (addr_i == `ADR_KBD_DATA);
   kbd_serial_link u_kbd (
      .clock_i(clock_i),
      .reset_i(reset_i),
      .tick_i(cnt_tick_w[2]),
      .rx_i(rx_s2_r),
      .tx_o(kb_tx_w),
      .tx_data_i(wdata_i[7:0]),
      .tx_start_i(kb_start_w),
      .tx_busy_o(kb_busy_w),
      .rx_data_o(kb_data_w),
      .rx_valid_o(kb_valid_w),
      .rx_ferr_o(kb_ferr_w)
   );
   // Receive buffer and sticky link flags, set wins
   always @(posedge clock_i) begin
      if (reset_i) begin
         kbd_rx_buf_r <= 8'h00;
         rx_full_r <= 1'b0;
         ferr_r <= 1'b0;
         ovr_r <= 1'b0;
         kbd_tx_o <= 1'b1;
      end else begin
         kbd_tx_o <= kb_tx_w;
         if (kb_valid_w) begin
            kbd_rx_buf_r <= kb_data_w;
         end
         rx_full_r <= kb_valid_w | (rx_full_r & ~data_rd_w);
         if (kb_ferr_w) begin
            ferr_r <= 1'b1;
         end else if (wr_i && addr_i == `ADR_KBD_STAT && wdata_i[`KS_FRAME]) begin
            ferr_r <= 1'b0;
         end
         if (kb_valid_w && rx_full_r && !data_rd_w) begin
            ovr_r <= 1'b1;
         end else if (wr_i && addr_i == `ADR_KBD_STAT && wdata_i[`KS_OVERRUN]) begin
            ovr_r <= 1'b0;
         end
      end
   end
   // ----------------------------------------
   // Interrupts
   // ----------------------------------------
   assign edge_clr_w = (wr_i && addr_i == `ADR_STATUS) ? wdata_i[`ST_EDGE_LO +: 2] : 2'b00;
   // twelve pins and two link levels, two timer edges
   assign status_w = {edge_st_r, ~kb_busy_w, rx_full_r, ext_s2_r};
   // Edge bits sticky, write one clears, set wins
   always @(posedge clock_i) begin
      if (reset_i) begin
         edge_st_r <= 2'b00;
      end else begin
         edge_st_r <= (edge_st_r & ~edge_clr_w) | cnt_tick_w[1:0];
      end
   end
   // Mask registers
   always @(posedge clock_i) begin
      if (reset_i) begin
         irq_mask_r <= 16'h0000;
         fiq_mask_r <= 16'h0000;
      end else if (wr_i) begin
         if (addr_i == `ADR_IRQ_MASK) begin
            irq_mask_r <= wdata_i;
         end else if (addr_i == `ADR_FIQ_MASK) begin
            fiq_mask_r <= wdata_i;
         end
      end
   end
   always @(posedge clock_i) begin
      if (reset_i) begin
         irq_req_r <= 16'h0000;
         fiq_req_r <= 16'h0000;
         irq_o <= 1'b0;
         fast_interrupt_request_o <= 1'b0;
      end else begin
         irq_req_r <= status_w & irq_mask_r;
         fiq_req_r <= status_w & fiq_mask_r;
         irq_o <= |(status_w & irq_mask_r);
         fast_interrupt_request_o <= |(status_w & fiq_mask_r);
      end
   end
   // ----------------------------------------
   // General I/O pins
   // ----------------------------------------
   // direction and value per pin
   always @(posedge clock_i) begin
      if (reset_i) begin
         gpio_dir_r <= 6'h00;
         gpio_val_r <= 6'h00;
         gpio_out_o <= 6'h00;
         gpio_oe_o <= 6'h00;
      end else begin
         if (wr_i && addr_i == `ADR_GPIO_DIR) begin
            gpio_dir_r <= wdata_i[5:0];
         end else if (wr_i && addr_i == `ADR_GPIO_OUT) begin
            gpio_val_r <= wdata_i[5:0];
         end
         gpio_out_o <= gpio_val_r;
         gpio_oe_o <= gpio_dir_r;
      end
   end
   // ----------------------------------------
   // Peripheral cycle engine
   // ----------------------------------------
   always @(posedge clock_i) begin
      if (reset_i) begin
         psel_time_r <= 14'h0000;
      end else if (wr_i && addr_i == `ADR_PSEL_TIME) begin
         psel_time_r <= wdata_i[13:0];
      end
   end
   // two timing bits per select line
   assign len_sel_w = (io_sel_i == 3'h7) ? 2'b00 : psel_time_r[2*io_sel_i +: 2];
   always @* begin
      case (len_sel_w)
         2'b00: len_cyc_w = `ACC_CYC0;
         2'b01: len_cyc_w = `ACC_CYC1;
         2'b10: len_cyc_w = `ACC_CYC2;
         default: len_cyc_w = `ACC_CYC3;
      endcase
      prd_nxt = ~io_write_i;
   end
   // Access, hold grant until request falls
   always @(posedge clock_i) begin
      if (reset_i) begin
         pst_r <= P_IDLE;
         pcnt_r <= 8'h00;
         psel_r <= 3'h7;
         periph_sel_o <= 7'h00;
         periph_rd_o <= 1'b0;
         periph_wr_o <= 1'b0;
         bus_buffer_en_o <= 1'b0;
         io_cycle_grant_o <= 1'b0;
      end else begin
         case (pst_r)
            P_IDLE: begin
               if (io_cycle_request_i) begin
                  pst_r <= P_ACC;
                  pcnt_r <= len_cyc_w - 8'h01;
                  psel_r <= io_sel_i;
                  periph_sel_o <= (io_sel_i == 3'h7) ? 7'h00 : (7'h01 << io_sel_i);
                  periph_rd_o <= prd_nxt;
                  periph_wr_o <= ~prd_nxt;
                  bus_buffer_en_o <= 1'b1;
               end
            end
            P_ACC: begin
               bus_buffer_en_o <= io_cycle_request_i;
               if (pcnt_r != 8'h00) begin
                  pcnt_r <= pcnt_r - 8'h01;
               end else if (io_cycle_request_i) begin
                  io_cycle_grant_o <= 1'b1;
                  periph_sel_o <= 7'h00;
                  periph_rd_o <= 1'b0;
                  periph_wr_o <= 1'b0;
                  bus_buffer_en_o <= 1'b0;
                  pst_r <= P_HOLD;
               end
            end
            P_HOLD: begin
               if (!io_cycle_request_i) begin
                  io_cycle_grant_o <= 1'b0;
                  pst_r <= P_IDLE;
               end
            end
            default: begin
               pst_r <= P_IDLE;
            end
         endcase
      end
   end
   // ----------------------------------------
   // Register read port
   // ----------------------------------------
   // Read data one cycle after strobe
   always @(posedge clock_i) begin
      if (reset_i) begin
         rdata_o <= 16'h0000;
      end else if (!rd_i) begin
         rdata_o <= 16'h0000;
      end else if (addr_i == `ADR_STATUS) begin
         rdata_o <= status_w;
      end else if (addr_i == `ADR_IRQ_MASK) begin
         rdata_o <= irq_mask_r;
      end else if (addr_i == `ADR_IRQ_REQ) begin
         rdata_o <= irq_req_r;
      end else if (addr_i == `ADR_FIQ_MASK) begin
         rdata_o <= fiq_mask_r;
      end else if (addr_i == `ADR_FIQ_REQ) begin
         rdata_o <= fiq_req_r;
      end else if (addr_i == `ADR_GPIO_DIR) begin
         rdata_o <= {10'h000, gpio_dir_r};
      end else if (addr_i == `ADR_GPIO_OUT) begin
         rdata_o <= {10'h000, gpio_val_r};
      end else if (addr_i == `ADR_GPIO_IN) begin
         rdata_o <= {10'h000, gpio_s2_r};
      end else if (addr_i == `ADR_KBD_DATA) begin
         rdata_o <= {8'h00, kbd_rx_buf_r};
      end else if (addr_i == `ADR_KBD_STAT) begin
         rdata_o <= {12'h000, ovr_r, ferr_r, rx_full_r, kb_busy_w};
      end else if (addr_i == `ADR_PSEL_TIME) begin
         rdata_o <= {2'b00, psel_time_r};
      end else if (addr_i[4:2] == 3'b011) begin
         rdata_o <= cnt_val_w[16*addr_i[1:0] +: 16];
      end else begin
         rdata_o <= 16'h0000;
      end
   end
endmodule // io_controller_serial_timers
`default_nettype wire

// [io_ctl_map.vh]
`ifndef IO_CTL_MAP_VH
`define IO_CTL_MAP_VH
// ----------------------------------------
// Register indices (word addresses)
// ----------------------------------------
`define ADR_STATUS 5'h00
`define ADR_IRQ_MASK 5'h01
`define ADR_IRQ_REQ 5'h02
`define ADR_FIQ_MASK 5'h03
`define ADR_FIQ_REQ 5'h04
`define ADR_GPIO_DIR 5'h05
`define ADR_GPIO_OUT 5'h06
`define ADR_GPIO_IN 5'h07
`define ADR_KBD_DATA 5'h08
`define ADR_KBD_STAT 5'h09
`define ADR_PSEL_TIME 5'h0A
`define ADR_CNT_BASE 5'h0C
// ----------------------------------------
// Status and keyboard field positions
// ----------------------------------------
`define ST_RX_FULL 12
`define ST_TX_IDLE 13
`define ST_EDGE_LO 14
`define KS_TX_BUSY 0
`define KS_RX_FULL 1
`define KS_FRAME 2
`define KS_OVERRUN 3
// ----------------------------------------
// Reset values and timing counts
// ----------------------------------------
`define CNT_RESET 16'hFFFF
`define ACC_CYC0 8'h02
`define ACC_CYC1 8'h04
`define ACC_CYC2 8'h08
`define ACC_CYC3 8'h10
`define KB_TICKS 4'hF
`define KB_HALF 4'h7
`define KB_FRAME 4'hB
`define KB_LAST_BIT 4'h9
`define KB_DATA_BITS 4'h8
`endif

// [reload_counter.v]
`default_nettype none
`include "io_ctl_map.vh"
module reload_counter #(
   parameter WIDTH = 16
) (
   // Clock and reset
   input wire clock_i,
   input wire reset_i,
   // Reload port
   input wire load_i,
   input wire [WIDTH-1:0] value_i,
   // Count and wrap
   output wire [WIDTH-1:0] count_o,
   output wire tick_o
);
   reg [WIDTH-1:0] reload_r;
   reg [WIDTH-1:0] count_r;
   reg tick_r;
   // Down count with reload on zero
   always @(posedge clock_i) begin
      if (reset_i) begin
         reload_r <= `CNT_RESET;
         count_r <= `CNT_RESET;
         tick_r <= 1'b0;
      end else if (load_i) begin
         reload_r <= value_i;
         count_r <= value_i;
         tick_r <= 1'b0;
      end else if (count_r == {WIDTH{1'b0}}) begin
         count_r <= reload_r;
         tick_r <= 1'b1;
      end else begin
         count_r <= count_r - 1'b1;
         tick_r <= 1'b0;
      end
   end
   assign count_o = count_r;
   assign tick_o = tick_r;
endmodule // reload_counter
`default_nettype wire

// [kbd_serial_link.v]
`default_nettype none
`include "io_ctl_map.vh"
module kbd_serial_link (
   // Clock and reset
   input wire clock_i,
   input wire reset_i,
   // Sampling tick and line
   input wire tick_i,
   input wire rx_i,
   output wire tx_o,
   // Transmit side
   input wire [7:0] tx_data_i,
   input wire tx_start_i,
   output wire tx_busy_o,
   // Receive side
   output wire [7:0] rx_data_o,
   output wire rx_valid_o,
   output wire rx_ferr_o
);
   localparam R_IDLE = 2'b00;
   localparam R_START = 2'b01;
   localparam R_DATA = 2'b10;
   reg [10:0] tx_sh_r;
   reg [3:0] tx_bits_r;
   reg [3:0] tx_tick_r;
   reg tx_busy_r;
   reg tx_line_r;
   reg [1:0] rx_st_r;
   reg [3:0] rx_tick_r;
   reg [3:0] rx_bit_r;
   reg [7:0] rx_sh_r;
   reg rx_bad_r;
   reg rx_valid_r;
   reg rx_ferr_r;
   // Transmitter: start, eight data, two stops
   always @(posedge clock_i) begin
      if (reset_i) begin
         tx_sh_r <= 11'h7FF;
         tx_bits_r <= 4'h0;
         tx_tick_r <= 4'h0;
         tx_busy_r <= 1'b0;
         tx_line_r <= 1'b1;
      end else begin
         tx_line_r <= tx_busy_r ? tx_sh_r[0] : 1'b1;
         if (tx_start_i && !tx_busy_r) begin
            tx_sh_r <= {2'b11, tx_data_i, 1'b0};
            tx_bits_r <= `KB_FRAME;
            tx_tick_r <= 4'h0;
            tx_busy_r <= 1'b1;
         end else if (tx_busy_r && tick_i) begin
            tx_tick_r <= tx_tick_r + 1'b1;
            if (tx_tick_r == `KB_TICKS) begin
               tx_sh_r <= {1'b1, tx_sh_r[10:1]};
               tx_bits_r <= tx_bits_r - 1'b1;
               if (tx_bits_r == 4'h1) begin
                  tx_busy_r <= 1'b0;
               end
            end
         end
      end
   end
   // Receiver with start filter and mid-bit sampling
   always @(posedge clock_i) begin
      if (reset_i) begin
         rx_st_r <= R_IDLE;
         rx_tick_r <= 4'h0;
         rx_bit_r <= 4'h0;
         rx_sh_r <= 8'h00;
         rx_bad_r <= 1'b0;
         rx_valid_r <= 1'b0;
         rx_ferr_r <= 1'b0;
      end else begin
         rx_valid_r <= 1'b0;
         rx_ferr_r <= 1'b0;
         case (rx_st_r)
            R_IDLE: begin
               rx_tick_r <= 4'h0;
               if (!rx_i) begin
                  rx_st_r <= R_START;
               end
            end
            R_START: begin
               if (tick_i) begin
                  if (rx_i) begin
                     rx_st_r <= R_IDLE;
                  end else if (rx_tick_r == `KB_HALF) begin
                     rx_st_r <= R_DATA;
                     rx_tick_r <= 4'h0;
                     rx_bit_r <= 4'h0;
                     rx_bad_r <= 1'b0;
                  end else begin
                     rx_tick_r <= rx_tick_r + 1'b1;
                  end
               end
            end
            R_DATA: begin
               if (tick_i) begin
                  rx_tick_r <= rx_tick_r + 1'b1;
                  if (rx_tick_r == `KB_TICKS) begin
                     rx_bit_r <= rx_bit_r + 1'b1;
                     if (rx_bit_r < `KB_DATA_BITS) begin
                        rx_sh_r <= {rx_i, rx_sh_r[7:1]};
                     end else if (!rx_i) begin
                        rx_bad_r <= 1'b1;
                     end
                     if (rx_bit_r == `KB_LAST_BIT) begin
                        rx_valid_r <= 1'b1;
                        rx_ferr_r <= rx_bad_r | ~rx_i;
                        rx_st_r <= R_IDLE;
                     end
                  end
               end
            end
            default: begin
               rx_st_r <= R_IDLE;
            end
         endcase
      end
   end
   assign tx_o = tx_line_r;
   assign tx_busy_o = tx_busy_r;
   assign rx_data_o = rx_sh_r;
   assign rx_valid_o = rx_valid_r;
   assign rx_ferr_o = rx_ferr_r;
endmodule // kbd_serial_link
`default_nettype wire

// [io_ctl_chk_sva.sv]
`default_nettype none
`include "io_ctl_map.vh"
module io_ctl_chk (
   // Clock and reset
   input wire logic clock_i,
   input wire logic reset_i,
   // Register port
   input wire logic [4:0] addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic wr_i,
   // Interrupts and pins
   input wire logic irq_o,
   input wire logic fast_interrupt_request_o,
   input wire logic [5:0] gpio_oe_o,
   // Cycle handshake and peripheral bus
   input wire logic io_cycle_request_i,
   input wire logic io_cycle_grant_o,
   input wire logic [6:0] periph_sel_o,
   input wire logic periph_rd_o,
   input wire logic periph_wr_o,
   input wire logic bus_buffer_en_o
);
   // ------------------------------
   // Sequences and properties
   // ------------------------------
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (reset_i);
   sequence s_mask_off(a);
      wr_i && addr_i == a && wdata_i == 16'h0000;
   endsequence
   sequence s_open;
      periph_sel_o != 7'h00 && !io_cycle_grant_o;
   endsequence
   sequence s_start;
      $rose(periph_rd_o || periph_wr_o) && io_cycle_request_i;
   endsequence
   AST_IRQ_MASKED: assert property (s_mask_off(`ADR_IRQ_MASK) |-> ##2 !irq_o)
      else $error("irq_o high after mask clear");
   AST_FAST_MASKED: assert property (
      s_mask_off(`ADR_FIQ_MASK) |-> ##2 !fast_interrupt_request_o)
      else $error("fast interrupt high after mask clear");
   AST_GPIO_DIR: assert property (wr_i && addr_i == `ADR_GPIO_DIR |-> ##2
      gpio_oe_o == $past(wdata_i[5:0], 2))
      else $error("gpio_oe_o misses direction write");
   AST_GRANT_REQ: assert property (!io_cycle_request_i |=> !io_cycle_grant_o)
      else $error("grant without request");
   AST_BUF_ISOLATE: assert property (
      !io_cycle_request_i && (periph_rd_o || periph_wr_o) |=> !bus_buffer_en_o)
      else $error("buffers joined while request withdrawn");
   AST_SEL_HOLD: assert property (s_open |=> io_cycle_grant_o ||
      (periph_sel_o == $past(periph_sel_o) && periph_rd_o == $past(periph_rd_o)))
      else $error("select or strobe changed before grant");
   AST_SEL_ONEHOT: assert property ($onehot0(periph_sel_o))
      else $error("several selects active");
   AST_ACCESS_BOUND: assert property (
      s_start |-> ##[1:16] (io_cycle_grant_o || !io_cycle_request_i))
      else $error("access longer than sixteen cycles");
endmodule // io_ctl_chk
bind io_controller_serial_timers io_ctl_chk io_ctl_chk_inst (
   .clock_i(clock_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
   .irq_o(irq_o), .fast_interrupt_request_o(fast_interrupt_request_o), .gpio_oe_o(gpio_oe_o),
   .io_cycle_request_i(io_cycle_request_i), .io_cycle_grant_o(io_cycle_grant_o),
   .periph_sel_o(periph_sel_o), .periph_rd_o(periph_rd_o), .periph_wr_o(periph_wr_o),
   .bus_buffer_en_o(bus_buffer_en_o));
`default_nettype wire

// [mem_ctl_model.sv]
`default_nettype none
module mem_ctl_model (
   // Clock
   input wire logic clock_i,
   // Cycle handshake
   output logic request_o,
   output logic [2:0] sel_o,
   output logic write_o,
   input wire logic grant_i
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle lines
   initial begin
      request_o = 1'b0;
      sel_o = 3'h7;
      write_o = 1'b0;
   end
   // ------------------------------
   // One I/O cycle, optionally withdrawn
   // ------------------------------
   // request on I/O access
   task automatic run_cycle(input logic [2:0] s, input logic w, input int drop_at,
         input int drop_len, output int lat);
      lat = 0;
      @(posedge clock_i);
      request_o <= 1'b1;
      sel_o <= s;
      write_o <= w;
      while (lat < 100) begin
         @(posedge clock_i);
         lat++;
         if (lat == drop_at) begin
            request_o <= 1'b0;
            repeat (drop_len) @(posedge clock_i);
            lat += drop_len;
            request_o <= 1'b1;
         end
         #1;
         if (grant_i === 1'b1) break;
      end
      @(posedge clock_i);
      request_o <= 1'b0;
      sel_o <= ~s; // Released lines lose the old value
      write_o <= ~w;
      for (int n = 0; n < 8 && grant_i !== 1'b0; n++) @(posedge clock_i);
      @(posedge clock_i);
   endtask
endmodule // mem_ctl_model
`default_nettype wire

// [io_controller_serial_timers_tb.sv]
`default_nettype none
`include "io_ctl_map.vh"
module io_controller_serial_timers_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TICK_DIV = 4;
   localparam int BIT_CYC = 16 * TICK_DIV;
   localparam logic [15:0] PSEL_CODES = 16'h1BE4;
   // ------------------------------
   // Signals and instances
   // ------------------------------
   logic clock_i, reset_i, wr_i, rd_i, kbd_rx_i, irq_o, fast_int, kbd_tx_o, baud_o;
   logic io_req, io_write, io_grant, periph_rd_o, periph_wr_o, buf_en;
   logic [2:0] io_sel;
   logic [4:0] addr_i;
   logic [5:0] gpio_in_i, gpio_out_o, gpio_oe_o;
   logic [6:0] periph_sel_o;
   logic [11:0] ext_irq_i;
   logic [15:0] wdata_i, rdata_o, got;
   logic [12:0] tx_bits;
   logic [36:0] rows [12];
   int err_count, cmp_count, lat;
   io_controller_serial_timers io_controller_serial_timers_inst (
      .clock_i(clock_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ext_irq_i(ext_irq_i), .irq_o(irq_o),
      .fast_interrupt_request_o(fast_int), .kbd_rx_i(kbd_rx_i), .kbd_tx_o(kbd_tx_o),
      .baud_o(baud_o), .gpio_in_i(gpio_in_i), .gpio_out_o(gpio_out_o), .gpio_oe_o(gpio_oe_o),
      .io_cycle_request_i(io_req), .io_sel_i(io_sel), .io_write_i(io_write),
      .io_cycle_grant_o(io_grant), .periph_sel_o(periph_sel_o), .periph_rd_o(periph_rd_o),
      .periph_wr_o(periph_wr_o), .bus_buffer_en_o(buf_en));
   mem_ctl_model mem_ctl_model_inst (.clock_i(clock_i), .request_o(io_req), .sel_o(io_sel),
      .write_o(io_write), .grant_i(io_grant));
   // Compare and bus tasks
   task automatic chk_word(input logic [15:0] g, input logic [15:0] e);
      cmp_count++;
      if (g !== e) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic chk_bit(input logic g, input logic e);
      chk_word({15'h0000, g}, {15'h0000, e});
   endtask
   task automatic reg_wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge clock_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clock_i);
      wr_i <= 1'b0;
   endtask
   task automatic reg_rd(input logic [4:0] a, output logic [15:0] d);
      @(posedge clock_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clock_i);
      rd_i <= 1'b0;
      #1;
      d = rdata_o;
   endtask
   task automatic send_kbd(input logic [7:0] d, input logic stop1);
      logic [10:0] f;
      f = {1'b1, stop1, d, 1'b0};
      for (int i = 0; i < 11; i++) begin
         @(posedge clock_i);
         kbd_rx_i <= f[i];
         repeat (BIT_CYC - 1) @(posedge clock_i);
      end
      repeat (BIT_CYC) @(posedge clock_i);
   endtask
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // Clock and watchdog
   initial begin
      clock_i = 1'b0;
      forever #5 clock_i = ~clock_i;
   end
   initial begin
      #900000;
      err_count++;
      end_sim();
   end
   // Main sequence
   initial begin
      {reset_i, wr_i, rd_i, kbd_rx_i, addr_i, wdata_i, ext_irq_i} = {4'b1001, 33'h0};
      gpio_in_i = 6'h2A;
      err_count = 0;
      cmp_count = 0;
      rows = '{{`ADR_IRQ_MASK, 16'hFFFF, 16'hFFFF}, {`ADR_IRQ_MASK, 16'h0000, 16'h0000},
         {`ADR_FIQ_MASK, 16'hFFFF, 16'hFFFF}, {`ADR_FIQ_MASK, 16'h0000, 16'h0000},
         {`ADR_IRQ_REQ, 16'hFFFF, 16'h0000}, {`ADR_FIQ_REQ, 16'hFFFF, 16'h0000},
         {`ADR_GPIO_DIR, 16'hFFFF, 16'h003F}, {`ADR_GPIO_OUT, 16'hFFFF, 16'h003F},
         {`ADR_GPIO_IN, 16'h0000, 16'h002A}, {`ADR_PSEL_TIME, 16'hFFFF, 16'h3FFF},
         {5'h0B, 16'hFFFF, 16'h0000}, {5'h1F, 16'h1234, 16'h0000}};
      repeat (8) @(posedge clock_i);
      reset_i <= 1'b0;
      foreach (rows[i]) begin
         reg_wr(rows[i][36:32], rows[i][31:16]);
         reg_rd(rows[i][36:32], got);
         chk_word(got, rows[i][15:0]);
      end
      chk_word({4'h0, gpio_oe_o, gpio_out_o}, 16'h0FFF);
      @(posedge clock_i);
      reset_i <= 1'b1;
      repeat (2) @(posedge clock_i);
      reset_i <= 1'b0;
      #1;
      chk_word({gpio_oe_o, gpio_out_o, irq_o, fast_int, kbd_tx_o, io_grant}, 16'h0002);
      for (int i = 0; i < 12; i++) begin
         @(posedge clock_i);
         ext_irq_i <= 12'h001 << i;
         repeat (4) @(posedge clock_i);
         reg_rd(`ADR_STATUS, got);
         chk_word(got & 16'h0FFF, 16'h0001 << i);
      end
      reg_wr(`ADR_IRQ_MASK, 16'h0800);
      reg_wr(`ADR_FIQ_MASK, 16'h0001);
      repeat (4) @(posedge clock_i);
      #1;
      chk_word({15'h0000, irq_o} | {14'h0000, fast_int, 1'b0}, 16'h0001);
      reg_rd(`ADR_IRQ_REQ, got);
      chk_word(got, 16'h0800);
      reg_wr(`ADR_IRQ_MASK, 16'h0000);
      ext_irq_i <= 12'h001;
      repeat (5) @(posedge clock_i);
      #1;
      chk_bit(fast_int, 1'b1);
      reg_wr(`ADR_FIQ_MASK, 16'h0000);
      reg_wr(`ADR_CNT_BASE, 16'h0003);
      reg_wr(`ADR_CNT_BASE + 5'h01, 16'h0003);
      repeat (8) @(posedge clock_i);
      reg_wr(`ADR_CNT_BASE, 16'hFFFF);
      reg_wr(`ADR_CNT_BASE + 5'h01, 16'hFFFF);
      reg_rd(`ADR_STATUS, got);
      chk_word(got & 16'hC000, 16'hC000);
      reg_wr(`ADR_STATUS, 16'hC000);
      reg_rd(`ADR_STATUS, got);
      chk_word(got & 16'hC000, 16'h0000);
      reg_wr(`ADR_CNT_BASE + 5'h03, 16'(TICK_DIV - 1));
      #1;
      got[0] = baud_o;
      for (int n = 0; n < 16 && baud_o === got[0]; n++) begin
         @(posedge clock_i);
         #1;
      end
      got[0] = baud_o;
      repeat (TICK_DIV - 1) @(posedge clock_i);
      #1;
      chk_bit(baud_o, got[0]);
      @(posedge clock_i);
      #1;
      chk_bit(baud_o, ~got[0]);
      reg_wr(`ADR_CNT_BASE + 5'h02, 16'(TICK_DIV - 1));
      kbd_rx_i <= 1'b0;
      repeat (4 * TICK_DIV) @(posedge clock_i);
      kbd_rx_i <= 1'b1;
      repeat (12 * BIT_CYC) @(posedge clock_i);
      reg_rd(`ADR_KBD_STAT, got);
      chk_word(got & 16'h0002, 16'h0000);
      send_kbd(8'h5A, 1'b1);
      reg_rd(`ADR_KBD_STAT, got);
      chk_word(got & 16'h0006, 16'h0002);
      reg_rd(`ADR_KBD_DATA, got);
      chk_word(got, 16'h005A);
      send_kbd(8'hC3, 1'b0);
      reg_rd(`ADR_KBD_STAT, got);
      chk_word(got & 16'h0006, 16'h0006);
      reg_rd(`ADR_KBD_DATA, got);
      chk_word(got, 16'h00C3);
      tx_bits = {4'hF, 8'hA5, 1'b0};
      reg_wr(`ADR_KBD_DATA, 16'h00A5);
      reg_wr(`ADR_KBD_DATA, 16'h00FF);
      for (int n = 0; n < 2 * BIT_CYC && kbd_tx_o !== 1'b0; n++) @(posedge clock_i);
      repeat (BIT_CYC / 2) @(posedge clock_i);
      for (int i = 0; i < 13; i++) begin
         #1;
         chk_bit(kbd_tx_o, tx_bits[i]);
         repeat (BIT_CYC) @(posedge clock_i);
      end
      reg_wr(`ADR_PSEL_TIME, PSEL_CODES);
      for (int k = 0; k < 7; k++) begin
         mem_ctl_model_inst.run_cycle(3'(k), k[0], 0, 0, lat);
         chk_word(16'(lat), 16'((2 << ((PSEL_CODES >> (2 * k)) & 16'h3)) + 1));
      end
      mem_ctl_model_inst.run_cycle(3'h6, 1'b1, 2, 6, lat);
      chk_word(16'(lat), 16'd9);
      mem_ctl_model_inst.run_cycle(3'h3, 1'b0, 2, 3, lat);
      chk_word(16'(lat), 16'd17);
      end_sim();
   end
endmodule // io_controller_serial_timers_tb
`default_nettype wire
